// ==== sadc_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module sadc_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic clock,
  input  wire logic rst_n,
  sadc_fifo_if.fifo f
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic [AW:0]      count_r;
  logic             do_wr;
  logic             do_rd;

  assign f.wr_ready = (count_r != (AW+1)'(DEPTH));
  assign f.rd_valid = (count_r != '0);
  assign f.rd_data  = mem_r[rd_ptr_r[AW-1:0]];
  assign do_wr      = f.wr_valid && f.wr_ready;
  assign do_rd      = f.rd_valid && f.rd_ready;

  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem_r[wr_ptr_r[AW-1:0]] <= f.wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= (wr_ptr_r[AW-1:0] == AW'(DEPTH-1)) ? '0
                    : wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= (rd_ptr_r[AW-1:0] == AW'(DEPTH-1)) ? '0
                    : rd_ptr_r + 1'b1;
      end
      case ({do_wr, do_rd})
        2'b10:   count_r <= count_r + 1'b1;
        2'b01:   count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end
endmodule : sadc_fifo

`default_nettype wire

// ==== sadc_fifo_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface sadc_fifo_if #(
  parameter int unsigned WIDTH = 10
);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport core (
    output wr_valid,
    output wr_data,
    input  wr_ready,
    input  rd_valid,
    input  rd_data,
    output rd_ready
  );

  modport fifo (
    input  wr_valid,
    input  wr_data,
    output wr_ready,
    output rd_valid,
    output rd_data,
    input  rd_ready
  );
endinterface : sadc_fifo_if

`default_nettype wire

// ==== sadc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module sadc_host (
  output logic      cs_n,
  output logic      sclk,
  input  wire logic dout_o,
  input  wire logic dout_oe_n
);
  logic [15:0] cap;
  wire logic   line;
  assign line = dout_oe_n ? 1'bz : dout_o;
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    cap = 16'h0000;
  end
  // Clock idles low outside frames; bits taken on falling edge
  task frame(input int n);
    cap = 16'h0000;
    cs_n <= 1'h0;
    #62.5;
    repeat (n) begin
      sclk <= 1'h1;
      #62.5;
      sclk <= 1'h0;
      cap = {cap[14:0], line};
      #62.5;
    end
    cs_n <= 1'h1;
    #700;
  endtask : frame
endmodule : sadc_host
`default_nettype wire

// ==== sadc_pkg.sv ====
// Function
// R01 - Select falling edge starts a conversion
// R02 - Output floats unless select is low
// R03 - One new output bit per clock rise
// R04 - Three zeros, then ten bits, MSB first
// R05 - Power-down low means shutdown, high normal
// R06 - Serial clock steps conversion and shifts data
// R07 - Select fall ends tracking, holds sample
// R08 - Conversion end returns sampler to track
// R09 - Conversion time equals clocks times period
// R10 - Host allows minimum acquisition before select
// R11 - Third clock rise presents the MSB
// R12 - Extra clocks give zeros, no disturbance
// R13 - Select rise clears counter, aborts conversion
package sadc_pkg;

  localparam int unsigned SADC_RES_BITS   = 10;
  localparam int unsigned SADC_FIFO_DEPTH = 16;
  localparam int unsigned SADC_CNT_W      = 4;

  // Serial clock rise numbers, counted from 1 after select falls
  localparam logic [3:0]  SADC_MSB_EDGE   = 4'h3;
  localparam logic [3:0]  SADC_LAST_EDGE  = 4'hC;
  localparam logic [3:0]  SADC_CNT_MAX    = 4'hF;

  localparam logic [9:0]  SADC_TRIAL_INIT = 10'h200;
  localparam logic [9:0]  SADC_CODE_RST   = 10'h000;

  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_CONV = 2'b01,
    SADC_DONE = 2'b11
  } sadc_state_t;

endpackage : sadc_pkg

// ==== sadc_readout.sv ====
`timescale 1ns/1ps
`default_nettype none

module sadc_readout
  import sadc_pkg::*;
#(
  parameter int unsigned RES_BITS   = SADC_RES_BITS,
  parameter int unsigned FIFO_DEPTH = SADC_FIFO_DEPTH
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                cs_n,
  input  wire logic                sclk,
  input  wire logic                power_down_n,
  input  wire logic                comp_above,
  output logic                     dout_o,
  output logic                     dout_oe_n,
  output logic [RES_BITS-1:0]      dac_code,
  output logic                     track_mode,
  output logic                     shutdown,
  output logic [RES_BITS-1:0]      result_data,
  output logic                     result_valid,
  input  wire logic                result_ready,
  output logic                     result_room
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned NPIN = 4;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_r;
  logic [NPIN-1:0] sync_r;
  logic [NPIN-1:0] prev_r;

  assign pin_raw = {comp_above, power_down_n, sclk, cs_n};

  // Syncs reset high: no false select fall after reset
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        meta_r[i] <= 1'b1;
        sync_r[i] <= 1'b1;
        prev_r[i] <= 1'b1;
      end else begin
        meta_r[i] <= pin_raw[i];
        sync_r[i] <= meta_r[i];
        prev_r[i] <= sync_r[i];
      end
    end
  end

  logic cs_low;
  logic pd_ok;
  logic comp_s;
  logic active;
  logic cs_fall;
  logic sclk_rise;

  assign cs_low    = ~sync_r[0];
  assign pd_ok     = sync_r[2];
  assign comp_s    = sync_r[3];
  assign active    = cs_low && pd_ok;                      // [R05]
  assign cs_fall   = prev_r[0] && !sync_r[0];              // [R01]
  assign sclk_rise = !prev_r[1] && sync_r[1];              // [R06]

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  sadc_state_t                state_r;
  logic [SADC_CNT_W-1:0]      edge_cnt_r;
  logic [SADC_CNT_W-1:0]      edge_nxt;
  logic [3:0]                 bit_idx;
  logic                       data_edge;
  logic                       last_edge;

  assign edge_nxt  = (edge_cnt_r == SADC_CNT_MAX) ? edge_cnt_r
                     : edge_cnt_r + 1'b1;
  assign bit_idx   = SADC_LAST_EDGE - edge_nxt;
  // Only CONV decides, so a bit_idx wrapped past zero is never used
  assign data_edge = (state_r == SADC_CONV) && sclk_rise
                     && (edge_nxt >= SADC_MSB_EDGE);       // [R11]
  assign last_edge = data_edge && (edge_nxt == SADC_LAST_EDGE);

  // Select rise or power-down aborts from any state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= SADC_IDLE;
    end else if (!active) begin
      state_r <= SADC_IDLE;                                // [R13]
    end else begin
      case (state_r)
        SADC_IDLE: begin
          if (cs_fall) begin
            state_r <= SADC_CONV;                          // [R01]
          end
        end
        SADC_CONV: begin
          if (last_edge) begin
            state_r <= SADC_DONE;                          // [R08]
          end
        end
        SADC_DONE: state_r <= SADC_DONE;
        default:   state_r <= SADC_IDLE;
      endcase
    end
  end

  // Saturating count keeps late clocks from wrapping
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      edge_cnt_r <= '0;
    end else if (!active || cs_fall) begin
      edge_cnt_r <= '0;                                    // [R13]
    end else if (sclk_rise && state_r != SADC_IDLE) begin
      edge_cnt_r <= edge_nxt;                              // [R09]
    end
  end

  // ---------------------------------------------------------------
  // Successive approximation register
  // ---------------------------------------------------------------
  logic [RES_BITS-1:0] trial_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trial_r <= SADC_CODE_RST;
    end else if (active && state_r == SADC_IDLE && cs_fall) begin
      trial_r <= SADC_TRIAL_INIT;                          // [R07]
    end else if (data_edge) begin
      trial_r[bit_idx] <= comp_s;                          // [R06]
      if (bit_idx != 4'h0) begin
        trial_r[bit_idx-4'h1] <= 1'b1;
      end
    end
  end

  assign dac_code   = trial_r;
  assign track_mode = (state_r != SADC_CONV);              // [R07] [R08]

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dout_o <= 1'b0;
    end else if (!active || cs_fall) begin
      dout_o <= 1'b0;                                      // [R04]
    end else if (sclk_rise) begin
      dout_o <= data_edge ? comp_s : 1'b0;                 // [R03] [R12]
    end
  end

  // Float follows select and power-down, never the state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dout_oe_n <= 1'b1;
    end else begin
      dout_oe_n <= !active;                                // [R02]
    end
  end

  // Registered so the flag cannot glitch
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shutdown <= 1'b0;
    end else begin
      shutdown <= !pd_ok;                                  // [R05]
    end
  end

  // ---------------------------------------------------------------
  // Result buffer
  // ---------------------------------------------------------------
  sadc_fifo_if #(.WIDTH(RES_BITS)) fq ();

  logic                pend_r;
  logic [RES_BITS-1:0] word_r;
  logic                done_d_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_d_r <= 1'b0;
    end else begin
      done_d_r <= last_edge;
    end
  end

  // Word is copied one cycle after the last decision lands
  // Pending word waits while the buffer is full
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      word_r <= SADC_CODE_RST;
    end else if (done_d_r) begin
      pend_r <= 1'b1;
      word_r <= trial_r;
    end else if (fq.wr_ready) begin
      pend_r <= 1'b0;
    end
  end

  assign fq.wr_valid = pend_r;
  assign fq.wr_data  = word_r;
  assign fq.rd_ready = result_ready;
  assign result_data  = fq.rd_data;
  assign result_valid = fq.rd_valid;
  assign result_room  = fq.wr_ready;

  sadc_fifo #(
    .WIDTH (RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .rst_n (rst_n),
    .f     (fq.fifo)
  );

endmodule : sadc_readout

`default_nettype wire

// ==== sadc_readout_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sadc_readout_monitor
  import sadc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       power_down_n,
  input wire logic       dout_o,
  input wire logic       dout_oe_n,
  input wire logic [9:0] dac_code,
  input wire logic       track_mode,
  input wire logic       shutdown
);
  logic       sclk_d_r;
  logic       cs_d_r;
  logic       pd_d_r;
  logic [3:0] quiet_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock) begin
    sclk_d_r <= sclk;
    cs_d_r <= cs_n;
    pd_d_r <= power_down_n;
  end
  // Cycles since the last serial clock rise, select change or power-down change
  always_ff @(posedge clock) begin
    if (!rst_n || (sclk && !sclk_d_r) || (cs_n != cs_d_r)
        || (power_down_n != pd_d_r)) quiet_r <= 4'h0;
    else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
  end
  a_float_idle: assert property (cs_n [*8] |-> dout_oe_n)
    else $error("output driven while deselected");
  a_lead_zero: assert property ($fell(cs_n) && !shutdown |->
    ##[2:6] (!dout_oe_n && !dout_o)) else $error("no low after select");
  a_hold_sample: assert property ($fell(cs_n) && !shutdown |->
    ##[2:6] !track_mode) else $error("sampler still tracking");
  a_cs_release: assert property ($rose(cs_n) |->
    ##8 (track_mode && dout_oe_n)) else $error("no return to track");
  a_dac_start: assert property ($fell(track_mode) |->
    ##[0:1] (dac_code == SADC_TRIAL_INIT)) else $error("bad first trial");
  a_dout_quiet: assert property (quiet_r > 4'h8 |-> $stable(dout_o))
    else $error("output moved without clock rise");
  a_shut_float: assert property (!power_down_n [*8] |->
    (dout_oe_n && shutdown)) else $error("not shut down");
  a_run_mode: assert property (power_down_n [*8] |-> !shutdown)
    else $error("shutdown while enabled");
endmodule : sadc_readout_monitor
bind sadc_readout sadc_readout_monitor i_sadc_readout_monitor (.clock,
  .rst_n, .cs_n, .sclk, .power_down_n, .dout_o, .dout_oe_n, .dac_code,
  .track_mode, .shutdown);
`default_nettype wire

// ==== test_serial_sar_adc_readout.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_serial_sar_adc_readout;
  logic       clock, rst_n, power_down_n, comp_above, result_ready;
  logic       dout_o, dout_oe_n, track_mode, shutdown;
  logic       result_valid, result_room;
  logic [9:0] dac_code, result_data, sample;
  wire logic  cs_n, sclk;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  logic [9:0] q[$];
  sadc_readout i_sadc_readout (.clock, .rst_n, .cs_n, .sclk, .power_down_n,
    .comp_above, .dout_o, .dout_oe_n, .dac_code, .track_mode, .shutdown,
    .result_data, .result_valid, .result_ready, .result_room);
  sadc_host i_sadc_host (.cs_n, .sclk, .dout_o, .dout_oe_n);
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  // Comparator: held sample at or above the trial code
  always @(posedge clock) comp_above <= (sample >= dac_code);
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test;
    end
  end
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask : chk_word
  task chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : chk_flag
  task end_of_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task conv(input logic [9:0] s);
    @(posedge clock) sample <= s;
    i_sadc_host.frame(15);
    q.push_back(s);
    chk_word(i_sadc_host.cap, {3'h0, s, 3'h0});
  endtask : conv
  task pop_chk;
    int t;
    t = 0;
    while (result_valid !== 1'h1 && t < 50) begin
      @(posedge clock);
      t++;
    end
    @(posedge clock) result_ready <= 1'h1;
    #1 chk_word({6'h00, result_data}, {6'h00, q.pop_front()});
    @(posedge clock) result_ready <= 1'h0;
    @(posedge clock);
  endtask : pop_chk
  initial begin
    rst_n = 1'h0;
    power_down_n = 1'h1;
    result_ready = 1'h0;
    sample = 10'h000;
    void'($urandom(75));
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
    repeat (4) @(posedge clock);
    conv(10'h000);
    conv(10'h3FF);
    repeat (14) conv(10'($urandom));
    chk_flag(result_room, 1'h0);
    chk_flag(track_mode, 1'h1);
    while (q.size() > 0) pop_chk;
    chk_flag(result_valid, 1'h0);
    chk_flag(result_room, 1'h1);
    @(posedge clock) sample <= 10'h155;
    i_sadc_host.frame(6);
    chk_flag(result_valid, 1'h0);
    conv(10'($urandom));
    pop_chk;
    @(posedge clock) power_down_n <= 1'h0;
    repeat (8) @(posedge clock);
    #1 chk_flag(shutdown, 1'h1);
    i_sadc_host.frame(15);
    chk_flag(result_valid, 1'h0);
    @(posedge clock) power_down_n <= 1'h1;
    repeat (8) @(posedge clock);
    conv(10'($urandom));
    pop_chk;
    end_of_test;
  end
endmodule : test_serial_sar_adc_readout
`default_nettype wire
